// file: bench/pin_pulse_source.sv
// Model of the pulse source that stands on the timer pin
`timescale 1ns/10ps
module pin_pulse_source (
	input wire logic clk_sys,
	input wire logic enable,
	input wire logic [7:0] halfCycles,
	output logic pinLine
);
	// Clock cycles spent in the current half period
	logic [7:0] phase;
	initial begin
		pinLine = 1'b1;
		phase = 8'h00;
	end
	// Idles high like a pulled-up line; toggles every half period while enabled
	always @(posedge clk_sys) begin
		if (!enable) begin
			pinLine <= 1'b1;
			phase <= 8'h00;
		end else if (phase == halfCycles - 8'h01) begin
			pinLine <= ~pinLine;
			phase <= 8'h00;
		end else begin
			phase <= phase + 8'h01;
		end
	end
endmodule // pin_pulse_source

// file: bench/timer_oneshot_measure_pwm16_bench.sv
// Self-checking bench of the one-shot, measurement and 16-bit PWM timer channel
`timescale 1ns/10ps
module timer_oneshot_measure_pwm16_bench;
	import timer_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	busReq_s bus = '0; // Register bus request
	neighbourOvf_s nbOvf = '0; // Neighbour overflow pulses
	logic [DATA_W-1:0] rdata, got;
	logic pinOut, pinOeN, irqRequest, overflowFlag, srcLine, srcOn = 1'b0;
	int miscompares = 0, checked = 0, cycles = 0, highCnt;
	// Pin level: device drives when its enable is low, else the source
	wire logic pinWire = pinOeN ? srcLine : pinOut;
	initial forever #25 clk_sys = ~clk_sys;
	timer_oneshot_measure_pwm16 i_timer_oneshot_measure_pwm16 (.clk_sys(clk_sys), .rst(rst),
		.ce(1'b1), .bus(bus), .rdata(rdata), .pinIn(pinWire), .pinOut(pinOut), .pinOeN(pinOeN),
		.subclkIn(1'b0), .neighbourOvf(nbOvf), .irqRequest(irqRequest),
		.overflowFlag(overflowFlag));
	pin_pulse_source i_pin_pulse_source (.clk_sys(clk_sys), .enable(srcOn),
		.halfCycles(8'h0a), .pinLine(srcLine));
	// ----------------------------------------------------------------
	// Bus tasks, compare and closing
	// ----------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		got = rdata;
	endtask
	task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Cuts a hung run short
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		check("ovf reset", 16'(overflowFlag), 16'h0001);
		rd(3'h7);
		check("unmapped", got, 16'h0000);
		// One-shot, software start, count of three
		wr(OFS_MODE, 16'h0031);
		wr(OFS_STATUS, 16'h0001);
		wr(OFS_TIMER, 16'h0003);
		wr(OFS_CTRL, 16'h0001);
		wr(OFS_CTRL, 16'h0003);
		check("os pin high", {pinOeN, pinOut}, 16'h0001);
		repeat (3) @(posedge clk_sys);
		#1;
		check("os end", {irqRequest, pinOut}, 16'h0002);
		rd(OFS_TIMER);
		check("os reload", got, 16'h0003);
		// One-shot stopped by clearing run
		wr(OFS_STATUS, 16'h0001);
		wr(OFS_TIMER, 16'h0100);
		wr(OFS_CTRL, 16'h0003);
		repeat (10) @(posedge clk_sys);
		wr(OFS_CTRL, 16'h0000);
		@(posedge clk_sys);
		#1;
		check("stop pin irq", {irqRequest, pinOut}, 16'h0002);
		rd(OFS_TIMER);
		check("stop reload", got, 16'h0100);
		// Period measurement, falling to falling, period of 20 cycles
		wr(OFS_MODE, 16'h0002);
		wr(OFS_CTRL, 16'h0001);
		wr(OFS_MODE, 16'h0002);
		check("ovf cleared", 16'(overflowFlag), 16'h0000);
		wr(OFS_STATUS, 16'h0001);
		srcOn <= 1'b1;
		for (int i = 0; i < 200 && irqRequest !== 1'b1; i++) @(posedge clk_sys);
		#1;
		check("meas irq", 16'(irqRequest), 16'h0001);
		rd(OFS_RELOAD);
		check("meas capture", got, 16'd19);
		srcOn <= 1'b0;
		wr(OFS_CTRL, 16'h0000);
		// 16-bit PWM started by a neighbour overflow, high time of five
		wr(OFS_MODE, 16'h0003);
		wr(OFS_TIMER, 16'h0005);
		wr(OFS_CTRL, 16'h0001);
		wr(OFS_STATUS, 16'h0001);
		@(posedge clk_sys);
		nbOvf.timerB <= 1'b1;
		@(posedge clk_sys);
		nbOvf.timerB <= 1'b0;
		highCnt = 0;
		for (int i = 0; i < 40; i++) begin
			#1;
			if (pinOut === 1'b1) highCnt++;
			@(posedge clk_sys);
		end
		#1;
		check("pwm high time", 16'(highCnt), 16'h0005);
		check("pwm irq", 16'(irqRequest), 16'h0001);
		end_sim();
	end
endmodule // timer_oneshot_measure_pwm16_bench

// file: hdl/count_source_prescaler.sv
// Count source prescaler: undivided, /8, /32 and subclock /32 ticks
`timescale 1ns/10ps
module count_source_prescaler #(
	parameter int DIV_A = timer_pkg::DIV_EIGHT,
	parameter int DIV_B = timer_pkg::DIV_THIRTYTWO
) (
	input logic clk_sys,
	input logic rst,
	input logic ce,
	input timer_pkg::srcSel_e srcSel,
	input logic subclkRise,
	output logic tick
);
	import timer_pkg::*;

	// Dividers wrap by overflow, so ratios must be powers of two
	if (DIV_A < 2 || (DIV_A & (DIV_A - 1)) != 0 || DIV_B < 2 || (DIV_B & (DIV_B - 1)) != 0)
	begin : gBadDiv
		$error("Divider ratios must be powers of two of at least 2");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [$clog2(DIV_A)-1:0] divA;   // Main clock /8 counter
		logic [$clog2(DIV_B)-1:0] divB;   // Main clock /32 counter
		logic [$clog2(DIV_B)-1:0] divSub; // Subclock edge /32 counter
	} preState_s;

	preState_s s_q;
	preState_s s_d;

	// Count every clock, and every subclock edge
	always_comb begin
		s_d = s_q;
		s_d.divA = s_q.divA + 1'b1;
		s_d.divB = s_q.divB + 1'b1;
		if (subclkRise) begin
			s_d.divSub = s_q.divSub + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Select the count source
	always_comb begin
		unique case (srcSel)
			SRC_UNDIV: tick = ce;
			SRC_DIV8: tick = ce & (&s_q.divA);
			SRC_DIV32: tick = ce & (&s_q.divB);
			SRC_SUB32: tick = ce & subclkRise & (&s_q.divSub);
		endcase
	end

endmodule // count_source_prescaler

// file: hdl/pin_edge_sync.sv
// Two-flop synchroniser with edge detection for one asynchronous input
`timescale 1ns/10ps
module pin_edge_sync (
	input logic clk_sys,
	input logic rst,
	input logic ce,
	input logic asyncIn,
	output logic level,
	output logic rise,
	output logic fall
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic meta;    // First stage, read only by the second
		logic sync;    // Second stage, safe level
		logic prev;    // Delayed safe level for edges
		logic [2:0] fill; // Ones shift in after reset until prev holds a real sample
	} syncState_s;

	syncState_s s_q;
	syncState_s s_d;

	// Shift the chain
	always_comb begin
		s_d = s_q;
		s_d.meta = asyncIn;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		s_d.fill = {s_q.fill[1:0], 1'b1};
	end

	// Register, frozen while ce is low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Edges are one clock wide and seen only while enabled
	// Held off until the chain is full, so a pin idling high gives no false edge
	assign level = s_q.sync;
	assign rise = ce & s_q.fill[2] & s_q.sync & ~s_q.prev;
	assign fall = ce & s_q.fill[2] & ~s_q.sync & s_q.prev;

endmodule // pin_edge_sync

// file: hdl/timer_oneshot_measure_pwm16.sv
// One 16-bit timer channel: one-shot, pulse period/width measurement, 16-bit PWM
`timescale 1ns/10ps
module timer_oneshot_measure_pwm16 (
	input logic clk_sys,
	input logic rst,
	input logic ce,
	input timer_pkg::busReq_s bus,
	output logic [timer_pkg::DATA_W-1:0] rdata,
	input logic pinIn,
	output logic pinOut,
	output logic pinOeN,
	input logic subclkIn,
	input timer_pkg::neighbourOvf_s neighbourOvf,
	output logic irqRequest,
	output logic overflowFlag
);
	import timer_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		modeReg_s modeReg;           // Software mode selection
		logic run;                   // Run flag
		logic active;                // One-shot or PWM count in progress
		logic retrig;                // Retrigger waits for next tick
		logic edgeSeen;              // First measurement edge taken
		logic [DATA_W-1:0] counter;  // Working counter
		logic [DATA_W-1:0] reload;   // Reload register, also capture
		logic [DATA_W-1:0] pwmPos;   // Ticks into the current PWM period
		logic irq;                   // Interrupt request bit
		logic ovf;                   // Overflow flag
		logic pinOut;                // Pin drive level
		logic pinOeN;                // Pin drive enable, low drives
		logic [DATA_W-1:0] rdata;    // Read data, valid one cycle
	} state_s;

	state_s s_q;
	state_s s_d;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Strobe qualified by one register offset
	function automatic logic regHit(input logic strobe, input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] ofs);
		regHit = strobe & (addr == ofs);
	endfunction

	// Neighbour overflow picked by the selector; alternate source depends on mode
	function automatic logic pickNeighbour(input neighSel_e sel, input logic useTimerA,
			input neighbourOvf_s ovf);
		logic picked;
		picked = 1'b0;
		unique case (sel)
			NB_TIMER_B: picked = ovf.timerB;
			NB_ALT: picked = useTimerA ? ovf.timerA : ovf.firstX;
			NB_OWN: picked = ovf.ownChannel;
			NB_NONE: picked = 1'b0;
		endcase
		pickNeighbour = picked;
	endfunction

	// Write strobes, frozen with the rest while ce is low
	logic wrMode;       // Mode register write
	logic wrCtrl;       // Control register write
	logic wrTimer;      // Timer register write
	logic wrStatus;     // Status register write
	logic runFall;      // Software clears a set run flag
	logic softStart;    // Software writes one to the start flag
	assign wrMode = ce & regHit(bus.wr, bus.addr, OFS_MODE);
	assign wrCtrl = ce & regHit(bus.wr, bus.addr, OFS_CTRL);
	assign wrTimer = ce & regHit(bus.wr, bus.addr, OFS_TIMER);
	assign wrStatus = ce & regHit(bus.wr, bus.addr, OFS_STATUS);
	assign runFall = wrCtrl & s_q.run & ~bus.wdata[CTRL_RUN_BIT];
	assign softStart = wrCtrl & bus.wdata[CTRL_START_BIT];

	// ----------------------------------------------------------------
	// Synchronisers and count source
	// ----------------------------------------------------------------
	logic pinRise;      // Rising edge on the timer pin
	logic pinFall;      // Falling edge on the timer pin
	logic subclkRise;   // Rising edge of the subclock
	logic tick;         // One count source tick

	pin_edge_sync uPinSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.asyncIn(pinIn),
		.level(),
		.rise(pinRise),
		.fall(pinFall)
	);

	pin_edge_sync uSubSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.asyncIn(subclkIn),
		.level(),
		.rise(subclkRise),
		.fall()
	);

	count_source_prescaler uPrescaler (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.srcSel(s_q.modeReg.srcSel),
		.subclkRise(subclkRise),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Start and edge selection
	// ----------------------------------------------------------------
	logic startEv;      // Selected one-shot start condition
	logic pwmStart;     // Selected neighbour overflow for PWM
	logic measEdge;     // Effective measurement edge

	always_comb begin
		unique case (s_q.modeReg.startSel)
			START_FALL: startEv = pinFall;
			START_RISE: startEv = pinRise;
			START_NEIGHBOUR: startEv = ce & pickNeighbour(s_q.modeReg.neighSel, 1'b0,
					neighbourOvf);
			START_SOFT: startEv = softStart;
		endcase
		pwmStart = ce & pickNeighbour(s_q.modeReg.neighSel, 1'b1, neighbourOvf);
		unique case (s_q.modeReg.measSel)
			MEAS_FALL: measEdge = pinFall;
			MEAS_RISE: measEdge = pinRise;
			MEAS_BOTH: measEdge = pinRise | pinFall;
			MEAS_NONE: measEdge = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [DATA_W-1:0] downCnt;
		downCnt = s_q.counter;
		s_d = s_q;
		s_d.rdata = WORD_RESET;
		// Register reads answer in the next cycle only
		if (regHit(bus.rd, bus.addr, OFS_MODE)) begin
			s_d.rdata = {{(DATA_W-MODE_W){1'b0}}, s_q.modeReg};
		end else if (regHit(bus.rd, bus.addr, OFS_CTRL)) begin
			s_d.rdata = {{(DATA_W-1){1'b0}}, s_q.run};
		end else if (regHit(bus.rd, bus.addr, OFS_TIMER)) begin
			s_d.rdata = s_q.counter;
		end else if (regHit(bus.rd, bus.addr, OFS_STATUS)) begin
			s_d.rdata = {{(DATA_W-2){1'b0}}, s_q.ovf, s_q.irq};
		end else if (regHit(bus.rd, bus.addr, OFS_RELOAD)) begin
			s_d.rdata = s_q.reload;
		end
		// Software writes; hardware sets further down win over clears
		if (wrMode) begin
			s_d.modeReg = modeReg_s'(bus.wdata[MODE_W-1:0]);
			if (s_q.run) begin
				s_d.ovf = 1'b0;
			end
		end
		if (wrCtrl) begin
			s_d.run = bus.wdata[CTRL_RUN_BIT];
		end
		if (wrTimer) begin
			s_d.reload = bus.wdata;
			if (!s_q.active) begin
				s_d.counter = bus.wdata;
			end
		end
		if (wrStatus && bus.wdata[STAT_IRQ_BIT]) begin
			s_d.irq = 1'b0;
		end
		// Mode behaviour
		unique case (s_q.modeReg.mode)
			MODE_ONESHOT: begin
				s_d.pinOeN = 1'b0;
				if (runFall) begin
					// Abort: reload, pin low, request
					s_d.active = 1'b0;
					s_d.retrig = 1'b0;
					s_d.counter = s_q.reload;
					s_d.pinOut = 1'b0;
					s_d.irq = 1'b1;
				end else if (s_q.run && !s_q.active && startEv) begin
					s_d.active = 1'b1;
					s_d.pinOut = 1'b1;
				end else if (s_q.active && tick) begin
					if (s_q.retrig) begin
						// Pending retrigger reloads on this tick
						s_d.counter = s_q.reload;
						s_d.retrig = 1'b0;
					end else if (s_q.counter <= COUNT_ONE) begin
						// Reaching zero ends the shot
						s_d.counter = s_q.reload;
						s_d.active = 1'b0;
						s_d.pinOut = 1'b0;
						s_d.irq = 1'b1;
					end else begin
						s_d.counter = s_q.counter - COUNT_ONE;
					end
				end
				if (s_q.active && s_d.active && startEv) begin
					s_d.retrig = 1'b1;
				end
			end
			MODE_MEASURE: begin
				s_d.pinOeN = 1'b1;
				s_d.pinOut = 1'b0;
				if (!s_q.run) begin
					s_d.edgeSeen = 1'b0;
				end else if (measEdge) begin
					// Edge wins over a tick in the same cycle
					s_d.reload = s_q.counter;
					s_d.counter = WORD_RESET;
					s_d.edgeSeen = 1'b1;
					if (s_q.edgeSeen) begin
						s_d.irq = 1'b1;
					end
				end else if (tick) begin
					// Counts on from whatever the counter holds
					s_d.counter = s_q.counter + COUNT_ONE;
					if (s_q.counter == COUNT_MAX) begin
						s_d.ovf = 1'b1;
						s_d.irq = 1'b1;
					end
				end
			end
			MODE_PWM16: begin
				s_d.pinOeN = 1'b0;
				if (runFall) begin
					// Counter frozen; request only if pin was high
					s_d.active = 1'b0;
					s_d.pinOut = 1'b0;
					if (s_q.pinOut) begin
						s_d.irq = 1'b1;
					end
				end else if (s_q.run && !s_q.active && pwmStart) begin
					s_d.active = 1'b1;
					s_d.counter = s_q.reload;
					s_d.pwmPos = WORD_RESET;
					s_d.pinOut = (s_q.reload != WORD_RESET);
				end else if (s_q.active && tick) begin
					if (s_q.counter != WORD_RESET) begin
						downCnt = s_q.counter - COUNT_ONE;
					end
					// High-to-low, or once a period when never high
					if (s_q.counter == COUNT_ONE ||
							(s_q.pwmPos == PWM_LAST && s_q.reload == WORD_RESET)) begin
						s_d.irq = 1'b1;
					end
					if (s_q.pwmPos == PWM_LAST) begin
						s_d.counter = s_q.reload;
						s_d.pwmPos = WORD_RESET;
						s_d.pinOut = (s_q.reload != WORD_RESET);
					end else begin
						s_d.counter = downCnt;
						s_d.pwmPos = s_q.pwmPos + COUNT_ONE;
						s_d.pinOut = (downCnt != WORD_RESET);
					end
				end
			end
			MODE_IDLE: begin
				s_d.pinOeN = 1'b1;
				s_d.pinOut = 1'b0;
				s_d.active = 1'b0;
			end
		endcase
		// A mode write restarts the sequencing
		if (wrMode) begin
			s_d.active = 1'b0;
			s_d.retrig = 1'b0;
			s_d.edgeSeen = 1'b0;
			s_d.pinOut = 1'b0;
			if (s_d.modeReg.mode != s_q.modeReg.mode &&
					(s_d.modeReg.mode == MODE_ONESHOT || s_d.modeReg.mode == MODE_PWM16)) begin
				s_d.irq = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.pinOeN <= 1'b1;
			s_q.ovf <= OVF_RESET;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign rdata = s_q.rdata;
	assign pinOut = s_q.pinOut;
	assign pinOeN = s_q.pinOeN;
	assign irqRequest = s_q.irq;
	assign overflowFlag = s_q.ovf;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_oneshot_start: assert property (
		ce && !wrMode && s_q.modeReg.mode == MODE_ONESHOT && s_q.run && !s_q.active &&
		startEv && !runFall |=> s_q.active && s_q.pinOut && !s_q.pinOeN)
		else $error("one-shot did not start with pin high");

	chk_oneshot_end: assert property (
		ce && !wrMode && !wrTimer && s_q.modeReg.mode == MODE_ONESHOT && s_q.active &&
		!s_q.retrig && tick && s_q.counter == COUNT_ONE && !runFall
		|=> !s_q.active && !s_q.pinOut && s_q.irq && s_q.counter == $past(s_q.reload))
		else $error("one-shot end at zero wrong");

	chk_oneshot_retrig: assert property (
		ce && !wrMode && !wrTimer && s_q.modeReg.mode == MODE_ONESHOT && s_q.active &&
		s_q.retrig && tick && !runFall |=> s_q.active && s_q.counter == $past(s_q.reload))
		else $error("retrigger did not reload");

	chk_oneshot_stop: assert property (
		ce && !wrMode && s_q.modeReg.mode == MODE_ONESHOT && runFall
		|=> !s_q.active && !s_q.pinOut && s_q.irq)
		else $error("one-shot abort wrong");

	chk_meas_first: assert property (
		ce && !wrMode && !wrStatus && s_q.modeReg.mode == MODE_MEASURE && s_q.run &&
		!s_q.edgeSeen && measEdge && !wrCtrl
		|=> s_q.counter == WORD_RESET && s_q.edgeSeen && s_q.irq == $past(s_q.irq))
		else $error("first edge handled wrong");

	chk_meas_capture: assert property (
		ce && !wrMode && !wrTimer && s_q.modeReg.mode == MODE_MEASURE && s_q.run &&
		s_q.edgeSeen && measEdge && !wrCtrl
		|=> s_q.counter == WORD_RESET && s_q.irq && s_q.reload == $past(s_q.counter))
		else $error("measurement capture wrong");

	chk_meas_overflow: assert property (
		ce && !wrMode && !wrTimer && s_q.modeReg.mode == MODE_MEASURE && s_q.run &&
		!measEdge && tick && s_q.counter == COUNT_MAX && !wrCtrl
		|=> s_q.ovf && s_q.irq && s_q.counter == WORD_RESET)
		else $error("overflow not flagged");

	chk_ovf_clear: assert property (
		ce && wrMode && s_q.run && !(s_q.modeReg.mode == MODE_MEASURE && !measEdge && tick &&
		s_q.counter == COUNT_MAX) |=> !s_q.ovf)
		else $error("overflow flag not cleared by mode write");

	chk_pwm_stop: assert property (
		ce && !wrMode && !wrTimer && s_q.modeReg.mode == MODE_PWM16 && runFall
		|=> !s_q.pinOut && !s_q.active && s_q.counter == $past(s_q.counter))
		else $error("PWM stop did not freeze");

	chk_pwm_reload: assert property (
		ce && !wrMode && s_q.modeReg.mode == MODE_PWM16 && s_q.active && tick &&
		s_q.pwmPos == PWM_LAST && !runFall && !wrTimer
		|=> s_q.active && s_q.pwmPos == WORD_RESET && s_q.counter == $past(s_q.reload))
		else $error("PWM period reload wrong");

	chk_irq_sticky: assert property (
		s_q.irq && !(wrStatus && bus.wdata[STAT_IRQ_BIT]) |=> s_q.irq)
		else $error("request bit dropped by hardware");

endmodule // timer_oneshot_measure_pwm16

// file: shared/timer_pkg.sv
// Shared constants, register map and carrier types of the one-shot/measure/PWM timer
package timer_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;                // Counter, reload and bus data width
	localparam int ADDR_W = 3;                 // Register address width
	localparam int MODE_W = 10;                // Used bits of the mode register

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_MODE = 3'h0;    // Mode and selection fields
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h1;    // Run flag and one-shot start flag
	localparam logic [ADDR_W-1:0] OFS_TIMER = 3'h2;   // Write: reload value, read: counter
	localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h3;  // Request bit and overflow flag
	localparam logic [ADDR_W-1:0] OFS_RELOAD = 3'h4;  // Reload register, holds captures

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN_BIT = 0;           // Run flag
	localparam int CTRL_START_BIT = 1;         // One-shot start flag, write one to start
	localparam int STAT_IRQ_BIT = 0;           // Request bit, write one to clear
	localparam int STAT_OVF_BIT = 1;           // Overflow flag, read only

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic OVF_RESET = 1'b1;                 // Overflow flag comes up set
	localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000; // Counter, reload, read data
	localparam logic [DATA_W-1:0] COUNT_MAX = 16'hffff;  // Last value before wrap
	localparam logic [DATA_W-1:0] COUNT_ONE = 16'h0001;  // Value whose next tick is zero
	localparam logic [DATA_W-1:0] PWM_LAST = 16'hfffe;   // Last tick of a 2^16-1 period
	localparam int DIV_EIGHT = 8;              // Ratio of the divide-by-eight source
	localparam int DIV_THIRTYTWO = 32;         // Ratio of both divide-by-32 sources

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_IDLE, MODE_ONESHOT, MODE_MEASURE, MODE_PWM16} timerMode_e;
	typedef enum logic [1:0] {SRC_UNDIV, SRC_DIV8, SRC_DIV32, SRC_SUB32} srcSel_e;
	typedef enum logic [1:0] {START_FALL, START_RISE, START_NEIGHBOUR, START_SOFT} startSel_e;
	typedef enum logic [1:0] {NB_TIMER_B, NB_ALT, NB_OWN, NB_NONE} neighSel_e;
	typedef enum logic [1:0] {MEAS_FALL, MEAS_RISE, MEAS_BOTH, MEAS_NONE} measSel_e;

	// ----------------------------------------------------------------
	// Carrier structs
	// ----------------------------------------------------------------
	typedef struct packed {
		measSel_e measSel;
		neighSel_e neighSel;
		startSel_e startSel;
		srcSel_e srcSel;
		timerMode_e mode;
	} modeReg_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} busReq_s;

	typedef struct packed {
		logic timerB;
		logic timerA;
		logic firstX;
		logic ownChannel;
	} neighbourOvf_s;

endpackage
